// >>> rpc_cfg.svh
// Constants for the periodic, run and alarm control block of the clock.
// How it works
// [RULE1] Power-on loads control two with 09 hex.
// [RULE2] Manual reset keeps oscillator and run bits.
// [RULE3] Standby never reinitialises control two.
// [RULE4] Periodic flag sets when chosen interval elapses.
// [RULE5] Writing 0 clears the periodic flag.
// [RULE6] Writing 1 sets it; flag requests interrupt.
// [RULE7] Rate field picks none up to two seconds.
// [RULE8] Oscillator enable halts or runs the oscillator.
// [RULE9] Adjust rounds seconds, carrying at thirty.
// [RULE10] Adjust also resets the divider chain.
// [RULE11] Adjust reads zero, seconds update promptly.
// [RULE12] Divider reset strobe clears prescaler, reads zero.
// [RULE13] Run bit stops or runs calendar counters.
// [RULE14] The 64 Hz counter ignores the run bit.
// [RULE15] Software stops counting before writing counters.
// [RULE16] Only enabled alarm fields take part.
// [RULE17] Full alarm match sets the alarm flag.
// [RULE18] Alarm enable turns match into interrupt request.
// [RULE19] Software rereads time after a carry.
// [RULE20] Software programs all registers after power-up.
// [RULE21] Software touches a register before module standby.
// [RULE22] Alarm flag clears on 0, holds on 1.
// [RULE23] Carry during read sets carry flag, interrupt.
// [RULE24] Tick from dividing oscillator; seconds every 64.
// [RULE25] Periodic timing comes from the divider chain.
`ifndef RPC_CFG_SVH
`define RPC_CFG_SVH
`define RPC_OFS_FLAG      12'h000
`define RPC_OFS_CTRL      12'h004
`define RPC_OFS_STAT      12'h008
`define RPC_CTRL_RESET    8'h09
`define RPC_FLAG_RESET    8'h00
`define RPC_BIT_PEF       7
`define RPC_BIT_RATE_LO   4
`define RPC_BIT_RATE_HI   6
`define RPC_BIT_OSC_EN    3
`define RPC_BIT_ADJ       2
`define RPC_BIT_DIV_RST   1
`define RPC_BIT_RUN       0
`define RPC_BIT_CF        7
`define RPC_BIT_CIE       4
`define RPC_BIT_AIE       3
`define RPC_BIT_AF        0
`define RPC_DIV_W         16
`define RPC_B_256         7
`define RPC_B_64          9
`define RPC_B_16          11
`define RPC_B_4           13
`define RPC_B_2           14
`define RPC_B_1           15
`define RPC_B_HALF        16
`define RPC_SEC_HALF      8'h30
`define RPC_N_ALARM       6
`endif

// >>> rpc_divider.sv
// Oscillator divider chain producing the periodic and seconds ticks.
`include "rpc_cfg.svh"
module rpc_divider #(
    parameter int W = `RPC_DIV_W
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         osc_tick,
    input  wire logic         clear,
    output logic [W-1:0]      count,
    output logic [7:0]        rate_tick
);
    import rpc_pkg::*;

    // A restart takes priority over a tick arriving in the same cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= '0;
        end else if (clear) begin // [RULE10] [RULE12]
            count <= '0;
        end else if (osc_tick) begin // [RULE24]
            count <= count + {{(W-1){1'b0}}, 1'b1};
        end
    end

    assign rate_tick[0] = 1'b0;
    generate
        for (genvar i = 1; i < 8; i++) begin : g_rate
            localparam int B = (i == 1) ? `RPC_B_256 : (i == 2) ? `RPC_B_64 :
                               (i == 3) ? `RPC_B_16  : (i == 4) ? `RPC_B_4  :
                               (i == 5) ? `RPC_B_2   : (i == 6) ? `RPC_B_1  :
                               `RPC_B_HALF;
            assign rate_tick[i] = osc_tick & (&count[B-1:0]); // [RULE25]
        end
    endgenerate
endmodule // rpc_divider

// >>> rpc_pkg.sv
// Types shared by the periodic, run and alarm control block.
package rpc_pkg;
    typedef logic [7:0] rpc_byte_t;
    typedef enum logic [2:0] {
        RPC_RATE_NONE, RPC_RATE_256, RPC_RATE_64, RPC_RATE_16,
        RPC_RATE_4, RPC_RATE_2, RPC_RATE_1, RPC_RATE_HALF
    } rpc_rate_e;
endpackage

// >>> rpc_top.sv
// Periodic, run and alarm control of the real-time clock behind an APB slave.
//
// Local design decisions: the APB slave port and the address map.
`include "rpc_cfg.svh"
module rpc_top #(
    parameter int ADDR_W = 12,
    parameter int DIV_W  = `RPC_DIV_W
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              manual_reset,
    input  wire logic              standby_mode,
    input  wire logic              clock_crystal_input,
    input  wire rpc_pkg::rpc_byte_t seconds_bcd,
    input  wire logic              counter_read,
    input  wire logic [5:0]        alarm_field_enable,
    input  wire logic [5:0]        alarm_field_match,
    output logic                   oscillator_run,
    output logic                   count_enable,
    output logic                   counter_write_allow,
    output logic                   seconds_clear,
    output logic                   minute_carry,
    output logic                   periodic_irq,
    output logic                   alarm_irq,
    output logic                   carry_irq
);
    import rpc_pkg::*;

    // Bit selects of the reset byte keep each retained bit at its own width.
    localparam rpc_byte_t CTRL_RST = `RPC_CTRL_RESET;

    logic        pready_q;
    logic        pslverr_q;
    logic [31:0] prdata_q;
    logic        xtal_s1_q;
    logic        xtal_s2_q;
    logic        xtal_s3_q;
    logic        pef_q;
    rpc_rate_e   rate_q;
    logic        osc_en_q;
    logic        run_q;
    logic        cf_q;
    logic        cie_q;
    logic        aie_q;
    logic        af_q;
    logic        match_q;
    logic        count_en_q;
    logic        sec_clr_q;
    logic        min_cy_q;
    logic        pirq_q;
    logic        airq_q;
    logic        cirq_q;
    logic        osc_q;
    logic        wallow_q;
    logic        osc_tick;
    logic        div_clear;
    logic [DIV_W-1:0] div_count;
    logic [7:0]  rate_tick;
    logic        acc;
    logic        wr_flag;
    logic        wr_ctrl;
    logic        hit;
    logic        mrst;
    logic        adj_wr;
    logic        match_all;
    logic        periodic_ev;
    logic        carry_ev;
    rpc_byte_t   ctrl_rd;
    rpc_byte_t   flag_rd;
    logic [31:0] rd_mux;

    // APB slave with one wait state so that pready and prdata come from flops.
    assign acc     = psel & penable & pready_q;
    assign hit     = (paddr == `RPC_OFS_FLAG) | (paddr == `RPC_OFS_CTRL) |
                     (paddr == `RPC_OFS_STAT);
    assign wr_flag = acc & pwrite & pstrb[0] & (paddr == `RPC_OFS_FLAG);
    assign wr_ctrl = acc & pwrite & pstrb[0] & (paddr == `RPC_OFS_CTRL);
    // Standby retains every bit, so a manual reset seen there is ignored.
    assign mrst    = manual_reset & ~standby_mode; // [RULE3]
    assign adj_wr  = wr_ctrl & pwdata[`RPC_BIT_ADJ];

    // Strobe bits are never stored, so they read back as zero.
    assign ctrl_rd = {pef_q, rate_q, osc_en_q, 1'b0, 1'b0, run_q}; // [RULE11] [RULE12]
    assign flag_rd = {cf_q, 2'b00, cie_q, aie_q, 2'b00, af_q};

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (paddr == `RPC_OFS_FLAG) begin
            rd_mux = {24'h00_0000, flag_rd};
        end else if (paddr == `RPC_OFS_CTRL) begin
            rd_mux = {24'h00_0000, ctrl_rd};
        end else if (paddr == `RPC_OFS_STAT) begin
            rd_mux = {25'h000_0000, osc_en_q, div_count[14:9]};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else if (psel && penable && !pready_q) begin
            pready_q  <= 1'b1;
            pslverr_q <= ~hit;
            prdata_q  <= pwrite ? 32'h0000_0000 : rd_mux;
        end else begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    // The crystal pin is foreign to pclk, so it is synchronised first.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xtal_s1_q <= 1'b0;
            xtal_s2_q <= 1'b0;
            xtal_s3_q <= 1'b0;
        end else begin
            xtal_s1_q <= clock_crystal_input;
            xtal_s2_q <= xtal_s1_q;
            xtal_s3_q <= xtal_s2_q;
        end
    end

    // Only the oscillator enable stops the chain; the run bit does not.
    assign osc_tick  = xtal_s2_q & ~xtal_s3_q & osc_en_q; // [RULE8] [RULE14]
    assign div_clear = wr_ctrl & (pwdata[`RPC_BIT_ADJ] | pwdata[`RPC_BIT_DIV_RST]); // [RULE10] [RULE12]

    rpc_divider #(
        .W         (DIV_W)
    ) u_div (
        .pclk      (pclk),
        .presetn   (presetn),
        .osc_tick  (osc_tick),
        .clear     (div_clear),
        .count     (div_count),
        .rate_tick (rate_tick)
    );

    assign periodic_ev = rate_tick[rate_q]; // [RULE7] [RULE25]
    assign carry_ev    = counter_read & rate_tick[2]; // [RULE23]
    assign match_all   = (|alarm_field_enable) &
                         (&(alarm_field_match | ~alarm_field_enable)); // [RULE16]

    // Second control register: retention bits and rate field.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rate_q   <= rpc_rate_e'(CTRL_RST[`RPC_BIT_RATE_HI:`RPC_BIT_RATE_LO]); // [RULE1]
            osc_en_q <= CTRL_RST[`RPC_BIT_OSC_EN];
            run_q    <= CTRL_RST[`RPC_BIT_RUN];
        end else if (mrst) begin
            rate_q   <= RPC_RATE_NONE; // [RULE2]
        end else if (wr_ctrl) begin
            rate_q   <= rpc_rate_e'(pwdata[`RPC_BIT_RATE_HI:`RPC_BIT_RATE_LO]); // [RULE7]
            osc_en_q <= pwdata[`RPC_BIT_OSC_EN]; // [RULE8]
            run_q    <= pwdata[`RPC_BIT_RUN]; // [RULE13]
        end
    end

    // A periodic event in the clearing cycle wins over the write of 0.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pef_q <= 1'b0;
        end else if (mrst) begin
            pef_q <= 1'b0;
        end else if (periodic_ev) begin
            pef_q <= 1'b1; // [RULE4]
        end else if (wr_ctrl) begin
            pef_q <= pwdata[`RPC_BIT_PEF]; // [RULE5] [RULE6]
        end
    end

    // First control register; the carry flag survives a manual reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cie_q <= 1'b0;
            aie_q <= 1'b0;
        end else if (mrst) begin
            cie_q <= 1'b0;
            aie_q <= 1'b0;
        end else if (wr_flag) begin
            cie_q <= pwdata[`RPC_BIT_CIE];
            aie_q <= pwdata[`RPC_BIT_AIE];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cf_q <= 1'b0;
        end else if (carry_ev) begin
            cf_q <= 1'b1; // [RULE23]
        end else if (wr_flag) begin
            cf_q <= pwdata[`RPC_BIT_CF];
        end
    end

    // The alarm flag sets on the rising edge of a full match only.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            match_q <= 1'b0;
            af_q    <= 1'b0;
        end else begin
            match_q <= match_all;
            if (match_all && !match_q) begin
                af_q <= 1'b1; // [RULE17]
            end else if (mrst) begin
                af_q <= 1'b0;
            end else if (wr_flag && !pwdata[`RPC_BIT_AF]) begin
                af_q <= 1'b0; // [RULE22]
            end
        end
    end

    // Counter-facing strobes and requests, all registered.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_en_q <= 1'b0;
            sec_clr_q  <= 1'b0;
            min_cy_q   <= 1'b0;
            pirq_q     <= 1'b0;
            airq_q     <= 1'b0;
            cirq_q     <= 1'b0;
            osc_q      <= 1'b1;
            wallow_q   <= 1'b0;
        end else begin
            count_en_q <= rate_tick[6] & run_q; // [RULE13] [RULE24]
            sec_clr_q  <= adj_wr; // [RULE9] [RULE11]
            min_cy_q   <= adj_wr & (seconds_bcd >= `RPC_SEC_HALF); // [RULE9]
            pirq_q     <= pef_q; // [RULE6]
            airq_q     <= af_q & aie_q; // [RULE18]
            cirq_q     <= cf_q & cie_q; // [RULE23]
            osc_q      <= osc_en_q; // [RULE8]
            wallow_q   <= ~run_q; // [RULE15]
        end
    end

    assign prdata              = prdata_q;
    assign pready              = pready_q;
    assign pslverr             = pslverr_q;
    assign oscillator_run      = osc_q;
    assign count_enable        = count_en_q;
    assign counter_write_allow = wallow_q;
    assign seconds_clear       = sec_clr_q;
    assign minute_carry        = min_cy_q;
    assign periodic_irq        = pirq_q;
    assign alarm_irq           = airq_q;
    assign carry_irq           = cirq_q;

    a_manual_keep: assert property (@(posedge pclk) disable iff (!presetn) // [RULE2]
        mrst && !wr_ctrl |=> osc_en_q == $past(osc_en_q) && run_q == $past(run_q)
        && rate_q == RPC_RATE_NONE && !pef_q)
        else $error("manual reset disturbed retained control bits");
    a_standby_hold: assert property (@(posedge pclk) disable iff (!presetn) // [RULE3]
        standby_mode && !acc && !periodic_ev |=> $stable(ctrl_rd))
        else $error("control register changed in standby");
    a_pef_event: assert property (@(posedge pclk) disable iff (!presetn) // [RULE4]
        periodic_ev && !mrst |=> pef_q ##1 pirq_q)
        else $error("periodic event lost");
    a_pef_clear: assert property (@(posedge pclk) disable iff (!presetn) // [RULE5]
        wr_ctrl && !pwdata[7] && !periodic_ev |=> !pef_q)
        else $error("periodic flag not cleared");
    a_pef_set: assert property (@(posedge pclk) disable iff (!presetn) // [RULE6]
        wr_ctrl && pwdata[7] && !mrst |=> pef_q)
        else $error("periodic flag not set by write");
    a_none_rate: assert property (@(posedge pclk) disable iff (!presetn) // [RULE7]
        rate_q == RPC_RATE_NONE && !pef_q && !acc && !mrst |=> !pef_q)
        else $error("periodic flag set with no rate");
    a_osc_halt: assert property (@(posedge pclk) disable iff (!presetn) // [RULE8]
        !osc_en_q && !div_clear |=> $stable(div_count))
        else $error("divider ran with oscillator halted");
    a_adj_round: assert property (@(posedge pclk) disable iff (!presetn) // [RULE9]
        adj_wr |=> sec_clr_q && (min_cy_q == ($past(seconds_bcd) >= 8'h30)))
        else $error("adjust rounding wrong");
    a_div_restart: assert property (@(posedge pclk) disable iff (!presetn) // [RULE10]
        div_clear |=> div_count == '0)
        else $error("divider not restarted");
    a_strobe_zero: assert property (@(posedge pclk) disable iff (!presetn) // [RULE12]
        pready && !pslverr && $past(paddr) == `RPC_OFS_CTRL |-> prdata[2:1] == 2'b00)
        else $error("strobe bit read back as one");
    a_run_gate: assert property (@(posedge pclk) disable iff (!presetn) // [RULE13]
        count_enable |-> $past(run_q))
        else $error("counting while stopped");
    a_alarm_set: assert property (@(posedge pclk) disable iff (!presetn) // [RULE17]
        match_all && !match_q |=> af_q ##1 (airq_q == $past(aie_q)))
        else $error("alarm match not flagged");
    a_af_hold: assert property (@(posedge pclk) disable iff (!presetn) // [RULE22]
        af_q && wr_flag && pwdata[0] && !mrst |=> af_q)
        else $error("alarm flag lost on write of one");
    a_carry_set: assert property (@(posedge pclk) disable iff (!presetn) // [RULE23]
        carry_ev |=> cf_q)
        else $error("carry during read not flagged");

    // Flag clears, request outputs, divider behaviour and counter-facing strobes.
    a_af_clear: assert property (@(posedge pclk) disable iff (!presetn) // [RULE22]
        wr_flag && !pwdata[`RPC_BIT_AF] && !(match_all && !match_q) |=> !af_q)
        else $error("alarm flag not cleared by write of zero");
    a_cf_clear: assert property (@(posedge pclk) disable iff (!presetn) // [RULE23]
        wr_flag && !pwdata[`RPC_BIT_CF] && !carry_ev |=> !cf_q)
        else $error("carry flag not cleared by write of zero");
    a_carry_irq: assert property (@(posedge pclk) disable iff (!presetn) // [RULE23]
        cf_q && cie_q |=> carry_irq)
        else $error("carry request missing");
    a_alarm_quiet: assert property (@(posedge pclk) disable iff (!presetn) // [RULE18]
        !aie_q |=> !alarm_irq)
        else $error("alarm request while disabled");
    a_pef_irq: assert property (@(posedge pclk) disable iff (!presetn) // [RULE6]
        pef_q |=> periodic_irq)
        else $error("periodic request missing");
    a_osc_out: assert property (@(posedge pclk) disable iff (!presetn) // [RULE8]
        !osc_en_q |=> !oscillator_run)
        else $error("oscillator left running");
    a_hz64_runs: assert property (@(posedge pclk) disable iff (!presetn) // [RULE14]
        osc_tick && !div_clear |=> div_count != $past(div_count))
        else $error("divider missed an oscillator tick");
    a_adj_fast: assert property (@(posedge pclk) disable iff (!presetn) // [RULE11]
        adj_wr |=> seconds_clear)
        else $error("adjust not passed to seconds counter");
    a_div_strobe: assert property (@(posedge pclk) disable iff (!presetn) // [RULE12]
        wr_ctrl && pwdata[`RPC_BIT_DIV_RST] |=> div_count == '0)
        else $error("divider reset strobe ignored");
    a_run_tick: assert property (@(posedge pclk) disable iff (!presetn) // [RULE24]
        rate_tick[6] && run_q |=> count_enable)
        else $error("seconds tick lost while running");
    a_run_stop: assert property (@(posedge pclk) disable iff (!presetn) // [RULE13]
        !run_q |=> !count_enable)
        else $error("seconds tick while stopped");
    a_write_allow: assert property (@(posedge pclk) disable iff (!presetn) // [RULE15]
        run_q |=> !counter_write_allow)
        else $error("counter writes allowed while counting");
    a_alarm_none: assert property (@(posedge pclk) disable iff (!presetn) // [RULE16]
        alarm_field_enable == 6'h00 && !af_q |=> !af_q)
        else $error("alarm flagged with no field enabled");

    c_periodic: cover property (@(posedge pclk) disable iff (!presetn) periodic_ev && pef_q);
    c_adjust:   cover property (@(posedge pclk) disable iff (!presetn) adj_wr ##1 minute_carry);
    c_alarm:    cover property (@(posedge pclk) disable iff (!presetn) alarm_irq);
    c_seconds:  cover property (@(posedge pclk) disable iff (!presetn) count_enable);
    c_carry:    cover property (@(posedge pclk) disable iff (!presetn) carry_irq);
endmodule // rpc_top

// >>> rpc_top_test.sv
// Self-checking testbench for the periodic, run and alarm control block.
module rpc_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    import rpc_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, manual_reset, standby_mode;
    logic        clock_crystal_input, counter_read, pready, pslverr, oscillator_run;
    logic        count_enable, counter_write_allow, seconds_clear, minute_carry;
    logic        periodic_irq, alarm_irq, carry_irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [3:0]  pstrb;
    logic [7:0]  seconds_bcd, s1;
    logic [5:0]  alarm_field_enable, alarm_field_match;
    logic        rerr;
    int          err_total, n_tests, n_sc, n_mc, n, per;

    rpc_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .manual_reset(manual_reset),
        .standby_mode(standby_mode), .clock_crystal_input(clock_crystal_input),
        .seconds_bcd(seconds_bcd), .counter_read(counter_read),
        .alarm_field_enable(alarm_field_enable), .alarm_field_match(alarm_field_match),
        .oscillator_run(oscillator_run), .count_enable(count_enable),
        .counter_write_allow(counter_write_allow), .seconds_clear(seconds_clear),
        .minute_carry(minute_carry), .periodic_irq(periodic_irq), .alarm_irq(alarm_irq),
        .carry_irq(carry_irq));

    always #20 pclk = ~pclk;
    // A fast crystal keeps the long divider counts inside a short run.
    always @(posedge pclk) clock_crystal_input <= ~clock_crystal_input;
    always @(posedge pclk) begin
        if (seconds_clear === 1'b1) n_sc <= n_sc + 1;
        if (minute_carry === 1'b1) n_mc <= n_mc + 1;
    end

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) chk("pready", 8'h01, 8'h00);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input string nm, input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        chk(nm, e, rdat[7:0]);
    endtask

    task automatic wait_cyc(input int c);
        repeat (c) @(posedge pclk);
    endtask

    task automatic wrap_up;
        $display("comparisons %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        wait_cyc(95000);
        err_total++;
        wrap_up;
    end

    initial begin
        pclk = 0;
        presetn = 0;
        psel = 0;
        penable = 0;
        pwrite = 0;
        paddr = '0;
        pwdata = '0;
        pstrb = 4'hF;
        manual_reset = 0;
        standby_mode = 0;
        clock_crystal_input = 0;
        counter_read = 0;
        seconds_bcd = 8'h00;
        alarm_field_enable = '0;
        alarm_field_match = '0;
        err_total = 0;
        n_tests = 0;
        n_sc = 0;
        n_mc = 0;
        wait_cyc(2);
        presetn <= 1'b1;
        rd_chk("ctrl_reset", 12'h004, 8'h09);
        rd_chk("flag_reset", 12'h000, 8'h00);
        chk("osc_run", 8'h01, {7'h00, oscillator_run});
        apb(1'b1, 12'h00C, 8'hFF);
        chk("slverr_wr", 8'h01, {7'h00, rerr});
        rd_chk("unmapped", 12'h00C, 8'h00);
        chk("slverr", 8'h01, {7'h00, rerr});
        apb(1'b1, 12'h004, 8'h9B);
        rd_chk("pef_set", 12'h004, 8'h99);
        wait_cyc(3);
        chk("pirq", 8'h01, {7'h00, periodic_irq});
        for (int r = 0; r < 8; r++) begin
            apb(1'b1, 12'h004, {1'b0, r[2:0], 4'hB});
            rd_chk("rate", 12'h004, {1'b0, r[2:0], 4'h9});
            if (r == 0) begin
                wait_cyc(600);
                chk("rate_none", 8'h00, {7'h00, periodic_irq});
            end else if (r < 4) begin
                n = 6;
                while (periodic_irq !== 1'b1 && n < 9000) begin
                    @(posedge pclk);
                    n++;
                end
                // Each crystal tick spans two clock cycles.
                per = (4 << (2 * r + 5)) / 2;
                chk("period", 8'h01, 8'(n >= per - 16 && n <= per + 16));
            end
        end
        apb(1'b1, 12'h004, 8'h78);
        apb(1'b1, 12'h000, 8'h18);
        @(posedge pclk) manual_reset <= 1'b1;
        @(posedge pclk) manual_reset <= 1'b0;
        rd_chk("manual_ctrl", 12'h004, 8'h08);
        rd_chk("manual_flag", 12'h000, 8'h00);
        chk("write_allow", 8'h01, {7'h00, counter_write_allow});
        apb(1'b1, 12'h004, 8'h68);
        standby_mode <= 1'b1;
        @(posedge pclk) manual_reset <= 1'b1;
        @(posedge pclk) manual_reset <= 1'b0;
        standby_mode <= 1'b0;
        rd_chk("standby_ctrl", 12'h004, 8'h68);
        apb(1'b1, 12'h004, 8'h00);
        wait_cyc(2);
        chk("osc_halt", 8'h00, {7'h00, oscillator_run});
        apb(1'b0, 12'h008, 8'h00);
        s1 = rdat[7:0];
        wait_cyc(2100);
        rd_chk("frozen", 12'h008, s1);
        apb(1'b1, 12'h004, 8'h08);
        apb(1'b0, 12'h008, 8'h00);
        s1 = rdat[7:0];
        wait_cyc(2100);
        apb(1'b0, 12'h008, 8'h00);
        chk("hz64_runs", 8'h01, 8'(s1 !== rdat[7:0]));
        alarm_field_enable <= 6'b00_0011;
        apb(1'b1, 12'h000, 8'h08);
        alarm_field_match <= 6'b00_0001;
        wait_cyc(5);
        rd_chk("partial", 12'h000, 8'h08);
        alarm_field_match <= 6'b00_0011;
        wait_cyc(5);
        rd_chk("alarm", 12'h000, 8'h09);
        chk("alarm_irq", 8'h01, {7'h00, alarm_irq});
        alarm_field_match <= 6'b00_0000;
        apb(1'b1, 12'h000, 8'h09);
        rd_chk("af_hold", 12'h000, 8'h09);
        apb(1'b1, 12'h000, 8'h10);
        rd_chk("af_clear", 12'h000, 8'h10);
        counter_read <= 1'b1;
        wait_cyc(1100);
        counter_read <= 1'b0;
        rd_chk("carry", 12'h000, 8'h90);
        chk("carry_irq", 8'h01, {7'h00, carry_irq});
        seconds_bcd <= 8'h30;
        apb(1'b1, 12'h004, 8'h0D);
        rd_chk("hz64_zero", 12'h008, 8'h40);
        chk("sec_clear", 8'h01, 8'(n_sc));
        chk("min_carry", 8'h01, 8'(n_mc));
        seconds_bcd <= 8'h29;
        apb(1'b1, 12'h004, 8'h0D);
        rd_chk("adj_read", 12'h004, 8'h09);
        chk("allow_off", 8'h00, {7'h00, counter_write_allow});
        chk("sec_clear2", 8'h02, 8'(n_sc));
        chk("min_carry2", 8'h01, 8'(n_mc));
        apb(1'b1, 12'h004, 8'h0B);
        n = 0;
        while (count_enable !== 1'b1 && n < 70000) begin
            @(posedge pclk);
            n++;
        end
        chk("second", 8'h01, 8'(n >= 65520 && n <= 65552));
        wrap_up;
    end
endmodule // rpc_top_test
